// ### common/gate_pkg.sv
package gate_pkg;

    // clock and time bases
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SEC_NS          = 1_000_000_000;
    localparam int BACKOFF_MS      = 500;
    localparam int NS_PER_MS       = 1_000_000;
    localparam int SEC_CYCLES      = SEC_NS / CLK_PERIOD_NS;
    localparam int BACKOFF_CYCLES  = (BACKOFF_MS * NS_PER_MS) / CLK_PERIOD_NS;

    // auto-close delay in whole seconds, zero means off
    localparam int          AUTO_CLOSE_W   = 6;
    localparam logic [5:0]  AUTO_CLOSE_OFF = 6'h00;
    localparam logic [5:0]  AUTO_CLOSE_MAX = 6'h3B;

    // gray codes along idle, opening, opened, closing, reopen, backoff
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_OPENING = 3'h1,
        ST_OPENED  = 3'h3,
        ST_CLOSING = 3'h2,
        ST_REOPEN  = 3'h6,
        ST_BACKOFF = 3'h7,
        ST_LOCKOUT = 3'h5
    } gate_state_t;

endpackage : gate_pkg

// ### core/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer #(
    parameter int LIMIT = 10
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic run,
    output logic      done
);
    localparam int W = $clog2(LIMIT + 1);

    logic [W-1:0] count;
    wire          at_end = (count == W'(LIMIT - 1));

    // restarts whenever run drops, so every period is a full one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            done <= run && at_end;
            if (!run || at_end) begin
                count <= '0;
            end else begin
                count <= count + 1'b1;
            end
        end
    end
endmodule : cycle_timer

// ### core/gate_control.sv
// Functional notes
// - separate open, close and stop buttons open, close or halt the gate.
// - held open button overrides stop and keeps reloading the auto-close countdown.
// - open obstruction while moving stops, backs off briefly, stops again.
// - after backoff, auto-close off and gate idle until a fresh command.
// - repeated open obstruction before a limit gives lockout with continuous alarm.
// - close obstruction while moving stops, then reopens gate fully.
// - open obstruction or entrapment during reopening forces lockout and alarm.
// - once close obstruction clears, auto-close expiry closes the gate.
// - reverse contact while closing reopens the gate fully.
// - free-exit loop opens gate and holds it open while triggered.
// - reverse loop while closing reopens the gate fully.
// - shadow loop keeps the gate fully open while asserted.
// - with auto-close set, gate closes after the programmed delay, capped at 59 s, once open.
`timescale 1ns/1ps
module gate_control
    import gate_pkg::*;
#(
    parameter int SEC_TICKS     = SEC_CYCLES,
    parameter int BACKOFF_TICKS = BACKOFF_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    open_btn,
    input  wire logic                    close_btn,
    input  wire logic                    stop_btn,
    input  wire logic                    open_obstruction_in,
    input  wire logic                    close_obstruction_in,
    input  wire logic                    entrapment_in,
    input  wire logic                    reverse_contact_in,
    input  wire logic                    open_loop_in,
    input  wire logic                    reverse_loop_in,
    input  wire logic                    shadow_loop_in,
    input  wire logic                    open_limit,
    input  wire logic                    close_limit,
    input  wire logic                    lockout_reset,
    input  wire logic [AUTO_CLOSE_W-1:0] auto_close_secs,
    output logic                         motor_open,
    output logic                         motor_close,
    output logic                         alarm,
    output logic                         locked_out
);
    gate_state_t             state;
    gate_state_t             next_state;
    logic                    retry_armed;
    logic                    autoclose_dis;
    logic                    backoff_close;
    logic [AUTO_CLOSE_W-1:0] remaining;
    logic                    sec_tick;
    logic                    backoff_done;

    wire moving       = (state == ST_OPENING) || (state == ST_CLOSING);
    // only the limit ahead counts; the one just left is still made on the first cycle
    wire limit_hit    = ((state == ST_OPENING) && open_limit) || ((state == ST_CLOSING) && close_limit);
    wire open_cmd     = open_btn | open_loop_in | shadow_loop_in;
    wire hold_open    = open_cmd | close_obstruction_in;
    wire reverse_trig = close_obstruction_in | reverse_contact_in | reverse_loop_in | shadow_loop_in;
    wire stop_ok      = stop_btn & ~open_btn;
    wire close_ok     = close_btn & ~hold_open & ~close_limit;
    wire auto_on      = (auto_close_secs != AUTO_CLOSE_OFF) && !autoclose_dis;
    wire count_run    = (state == ST_OPENED) && auto_on && !hold_open;
    wire auto_expire  = count_run && (remaining == AUTO_CLOSE_OFF);
    wire enter_back   = (next_state == ST_BACKOFF) && (state != ST_BACKOFF);
    wire fresh_start  = (state == ST_IDLE) && (next_state != ST_IDLE);
    wire next_backoff_close = enter_back ? (state == ST_OPENING) : backoff_close;
    wire next_motor_open  = (next_state == ST_OPENING) || (next_state == ST_REOPEN)
                            || ((next_state == ST_BACKOFF) && !next_backoff_close);
    wire next_motor_close = (next_state == ST_CLOSING)
                            || ((next_state == ST_BACKOFF) && next_backoff_close);
    wire next_locked      = (next_state == ST_LOCKOUT);

    cycle_timer #(.LIMIT(SEC_TICKS)) u_sec_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (count_run),
        .done   (sec_tick)
    );

    cycle_timer #(.LIMIT(BACKOFF_TICKS)) u_backoff_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (state == ST_BACKOFF),
        .done   (backoff_done)
    );

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (open_cmd) begin
                    next_state = ST_OPENING;
                end else if (close_ok) begin
                    next_state = ST_CLOSING;
                end
            end
            ST_OPENING: begin
                if (open_obstruction_in) begin
                    next_state = retry_armed ? ST_LOCKOUT : ST_BACKOFF;
                end else if (close_obstruction_in) begin
                    next_state = ST_REOPEN;
                end else if (stop_ok) begin
                    next_state = ST_IDLE;
                end else if (open_limit) begin
                    next_state = ST_OPENED;
                end
            end
            ST_CLOSING: begin
                if (open_obstruction_in) begin
                    next_state = retry_armed ? ST_LOCKOUT : ST_BACKOFF;
                end else if (reverse_trig) begin
                    next_state = ST_REOPEN;
                end else if (open_btn || open_loop_in) begin
                    next_state = ST_OPENING;
                end else if (stop_btn || close_limit) begin
                    next_state = ST_IDLE;
                end
            end
            ST_OPENED: begin
                if (close_ok || auto_expire) begin
                    next_state = ST_CLOSING;
                end
            end
            ST_BACKOFF: begin
                if (backoff_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_REOPEN: begin
                if (open_obstruction_in || entrapment_in) begin
                    next_state = ST_LOCKOUT;
                end else if (open_limit) begin
                    next_state = ST_OPENED;
                end
            end
            ST_LOCKOUT: begin
                if (lockout_reset) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state         <= ST_IDLE;
            backoff_close <= 1'b0;
            motor_open    <= 1'b0;
            motor_close   <= 1'b0;
            alarm         <= 1'b0;
            locked_out    <= 1'b0;
        end else begin
            state         <= next_state;
            backoff_close <= next_backoff_close;
            motor_open    <= next_motor_open;
            motor_close   <= next_motor_close;
            alarm         <= next_locked;
            locked_out    <= next_locked;
        end
    end

    // retry memory, set wins over limit clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            retry_armed <= 1'b0;
        end else if (enter_back) begin
            retry_armed <= 1'b1;
        end else if (limit_hit || state == ST_LOCKOUT) begin
            retry_armed <= 1'b0;
        end
    end

    // auto-close off until a fresh command
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            autoclose_dis <= 1'b0;
        end else if (enter_back) begin
            autoclose_dis <= 1'b1;
        end else if (fresh_start) begin
            autoclose_dis <= 1'b0;
        end
    end

    // countdown reloads while any hold is present
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            remaining <= AUTO_CLOSE_OFF;
        end else if (!count_run) begin
            remaining <= (auto_close_secs > AUTO_CLOSE_MAX) ? AUTO_CLOSE_MAX : auto_close_secs;
        end else if (sec_tick && remaining != AUTO_CLOSE_OFF) begin
            remaining <= remaining - 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_locked;
        (state == ST_LOCKOUT) && alarm && locked_out && !motor_open && !motor_close;
    endsequence

    sequence s_reopening;
        (state == ST_REOPEN) && motor_open && !motor_close;
    endsequence

    a_button_close: assert property ((state == ST_IDLE) && !open_cmd && close_ok
        |=> (state == ST_CLOSING) && motor_close) else $error("close button did not start closing");
    a_open_overrides_stop: assert property ((state == ST_OPENING) && open_btn && stop_btn
        && !open_obstruction_in && !close_obstruction_in && !open_limit
        |=> state == ST_OPENING) else $error("stop halted a held open");
    a_obstruct_backoff: assert property (moving && open_obstruction_in && !retry_armed
        |=> (state == ST_BACKOFF) && (motor_close == $past(state == ST_OPENING)))
        else $error("open obstruction gave no backoff");
    a_backoff_idle: assert property ((state == ST_BACKOFF) && backoff_done
        |=> (state == ST_IDLE) && autoclose_dis && !motor_open && !motor_close)
        else $error("backoff did not end idle with auto-close off");
    a_retry_lockout: assert property (moving && open_obstruction_in && retry_armed
        |=> s_locked) else $error("repeat obstruction missed lockout");
    a_close_obs_reopen: assert property ((state == ST_CLOSING) && close_obstruction_in
        && !open_obstruction_in |=> s_reopening) else $error("close obstruction missed reopen");
    a_reopen_fault: assert property ((state == ST_REOPEN) && (open_obstruction_in || entrapment_in)
        |=> s_locked) else $error("fault during reopen missed lockout");
    a_auto_close: assert property (auto_expire |=> (state == ST_CLOSING) && motor_close)
        else $error("auto-close expiry did not close");
    a_reverse_contact: assert property ((state == ST_CLOSING) && reverse_contact_in
        && !open_obstruction_in |=> s_reopening) else $error("reverse contact missed reopen");
    a_open_loop_hold: assert property ((state == ST_OPENED) && open_loop_in
        |=> state == ST_OPENED) else $error("gate left open with loop set");
    a_reverse_loop: assert property ((state == ST_CLOSING) && reverse_loop_in
        && !open_obstruction_in |=> s_reopening) else $error("reverse loop missed reopen");
    a_shadow_hold: assert property ((state == ST_OPENED) && shadow_loop_in
        |=> (state == ST_OPENED) && !motor_close) else $error("gate left open with shadow set");
    a_count_reload: assert property ((state == ST_OPENED) && hold_open && (auto_close_secs <= AUTO_CLOSE_MAX)
        |=> remaining == $past(auto_close_secs)) else $error("countdown ran during hold");
    a_delay_clamp: assert property (!count_run && (auto_close_secs > AUTO_CLOSE_MAX)
        |=> remaining == AUTO_CLOSE_MAX) else $error("long delay not clamped");
    a_lockout_stays: assert property ((state == ST_LOCKOUT) && !lockout_reset
        |=> s_locked) else $error("lockout left without reset");
endmodule : gate_control

// ### test/gate_plant.sv
`timescale 1ns/1ps
module gate_plant #(
    parameter int TRAVEL = 40
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic motor_open,
    input  wire logic motor_close,
    output logic      open_limit,
    output logic      close_limit
);
    int pos;
    // one step of leaf travel per driven cycle, hard stops at both ends
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pos <= 0;
        end else if (motor_open && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (motor_close && pos > 0) begin
            pos <= pos - 1;
        end
    end
    assign open_limit  = (pos == TRAVEL);
    assign close_limit = (pos == 0);
endmodule : gate_plant

// ### test/gate_control_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) check(nm, 32'(e), 32'(a))
`define WAITC(c, n) begin k = 0; while (!(c) && k < (n)) begin tick(1); k++; end end
module gate_control_bench;
    import gate_pkg::*;
    localparam int SEC_T = 20;
    logic       clk, resetn, open_btn, close_btn, stop_btn, lockout_reset, entrapment_in;
    logic       open_obstruction_in, close_obstruction_in, reverse_contact_in;
    logic       open_loop_in, reverse_loop_in, shadow_loop_in, open_limit, close_limit;
    logic       motor_open, motor_close, alarm, locked_out;
    logic [5:0] auto_close_secs;
    int         miscompares, total_checks, cycles, k, n, h, s;
    integer     seed;
    gate_control #(.SEC_TICKS(SEC_T), .BACKOFF_TICKS(8)) u_gate_control (
        .clk(clk), .resetn(resetn), .open_btn(open_btn), .close_btn(close_btn), .stop_btn(stop_btn),
        .open_obstruction_in(open_obstruction_in), .close_obstruction_in(close_obstruction_in),
        .entrapment_in(entrapment_in), .reverse_contact_in(reverse_contact_in), .open_loop_in(open_loop_in),
        .reverse_loop_in(reverse_loop_in), .shadow_loop_in(shadow_loop_in), .open_limit(open_limit),
        .close_limit(close_limit), .lockout_reset(lockout_reset), .auto_close_secs(auto_close_secs),
        .motor_open(motor_open), .motor_close(motor_close), .alarm(alarm), .locked_out(locked_out));
    gate_plant u_gate_plant (.clk(clk), .resetn(resetn), .motor_open(motor_open),
        .motor_close(motor_close), .open_limit(open_limit), .close_limit(close_limit));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask : tick
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] a);
        total_checks++;
        if (a !== e) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, e, a);
        end
    endtask : check
    // index map keeps scenario tables short
    task automatic set_in(input int i, input logic v);
        case (i)
            0: open_btn = v;
            1: open_loop_in = v;
            2: shadow_loop_in = v;
            3: close_obstruction_in = v;
            4: reverse_contact_in = v;
            5: reverse_loop_in = v;
            6: close_btn = v;
            7: stop_btn = v;
            8: open_obstruction_in = v;
            9: entrapment_in = v;
            default: lockout_reset = v;
        endcase
    endtask : set_in
    task automatic pulse(input int i);
        set_in(i, 1);
        tick(1);
        set_in(i, 0);
    endtask : pulse
    task automatic close_after(input int sec);
        n = 0;
        while (!motor_close && n < sec * SEC_T + 10) begin
            tick(1);
            n++;
        end
        `CHK("auto close delay", 1, n >= sec * SEC_T - 2 && n <= sec * SEC_T + 3);
        `WAITC(close_limit && !motor_close, 300)
    endtask : close_after
    task automatic test_done();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    initial begin
        seed = 32'hB391;
        for (int i = 0; i < 11; i++) set_in(i, 0);
        auto_close_secs = 6'h00;
        resetn = 0;
        tick(2);
        resetn = 1;
        pulse(0);
        `WAITC(motor_open, 2)
        `CHK("open run", 1, motor_open);
        `WAITC(open_limit && !motor_open, 300)
        `CHK("opened stays", 0, motor_close);
        pulse(6);
        tick(5);
        `CHK("closing", 1, motor_close);
        pulse(7);
        tick(2);
        `CHK("stopped", 0, motor_close | motor_open);
        `WAITC(0, 4)
        pulse(0);
        `WAITC(open_limit && !motor_open, 300)
        for (int i = 2; i < 6; i++) begin
            pulse(6);
            tick(3 + ($unsigned($random(seed)) % 6));
            pulse(i);
            `WAITC(motor_open, 2)
            `CHK("reverse to open", 1, motor_open);
            `WAITC(open_limit && !motor_open, 300)
            `CHK("reopen no lockout", 0, locked_out);
        end
        pulse(6);
        tick(8);
        pulse(3);
        tick(3);
        pulse(9);
        tick(2);
        `CHK("reopen lockout", 1, locked_out & alarm);
        pulse(0);
        tick(3);
        `CHK("locked refuses", 0, motor_open | motor_close);
        `CHK("alarm held", 1, alarm);
        pulse(10);
        tick(2);
        `CHK("lockout left", 0, locked_out | alarm);
        pulse(6);
        `WAITC(close_limit && !motor_close, 300)
        auto_close_secs = 6'h02;
        pulse(0);
        tick(15);
        pulse(8);
        `WAITC(motor_close, 2)
        `CHK("backoff", 1, motor_close & ~motor_open);
        `WAITC(!motor_close, 30)
        tick(80);
        `CHK("idle after backoff", 0, motor_open | motor_close);
        pulse(0);
        tick(3);
        pulse(8);
        tick(2);
        `CHK("retry lockout", 1, locked_out & alarm);
        pulse(10);
        tick(1);
        pulse(6);
        `WAITC(close_limit && !motor_close, 300)
        for (h = 0; h < 4; h++) begin
            s = 1 + ($unsigned($random(seed)) % 3);
            // out-of-range delay must clamp to the longest one
            if (h == 3) s = int'(AUTO_CLOSE_MAX);
            auto_close_secs = (h == 3) ? 6'h3F : 6'(s);
            if (h < 2) begin
                set_in(h, 1);
            end else begin
                pulse(0);
                set_in(h, 1);
            end
            tick(5);
            pulse(7);
            tick(1);
            if (h == 0) `CHK("stop overridden", 1, motor_open);
            if (h != 0) pulse(0);
            `WAITC(open_limit && !motor_open, 300)
            `CHK("hold opened", 1, open_limit);
            tick(60 + s * SEC_T);
            `CHK("hold keeps open", 0, motor_close);
            set_in(h, 0);
            close_after(s);
        end
        test_done();
    end
endmodule : gate_control_bench
